// >>> logic/fchp_pkg.sv
`default_nettype none
package fchp_pkg;

    // card personality, chosen at setup
    typedef enum logic [1:0] {
        FCHP_MODE_MEM,
        FCHP_MODE_IO,
        FCHP_MODE_ATA
    } fchp_mode_e;

    // lane selection decoded from the enables and address line zero
    typedef enum logic [2:0] {
        FCHP_XFER_NONE,
        FCHP_XFER_WORD,
        FCHP_XFER_EVEN,
        FCHP_XFER_ODD_LO,
        FCHP_XFER_ODD_HI
    } fchp_xfer_e;

    // target space of an access
    typedef enum logic [2:0] {
        FCHP_TGT_NONE,
        FCHP_TGT_ATTR,
        FCHP_TGT_TASK,
        FCHP_TGT_IO,
        FCHP_TGT_ATA_CMD,
        FCHP_TGT_ATA_CTL
    } fchp_tgt_e;

    localparam int FCHP_ADDR_W     = 11;
    localparam int FCHP_ATA_ADDR_W = 3;
    localparam int FCHP_SYNC_LEN   = 3;

    // reset values
    localparam logic        FCHP_RST_MASTER = 1'b1;
    localparam logic [1:0]  FCHP_RST_MODE   = 2'h0;

endpackage : fchp_pkg
`default_nettype wire

// >>> logic/fchp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// three-stage input filter: stage one only feeds stage two
module fchp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // plain shift chain; reset loads the idle levels of the pins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_q <= rst_val_i;
            s2_q <= rst_val_i;
            s3_q <= rst_val_i;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a bit moves only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_q <= rst_val_i;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    // caller ties rst_val_i to the idle map, so no false edge follows reset
    assign sync_o = out_q;

endmodule // fchp_sync
`default_nettype wire

// >>> logic/fchp_pins.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [R1] memory and I/O modes decode the full eleven-bit address, A10 msb.
// [R2] ATA mode decodes only the low three address lines; host grounds others.
// [R3] memory mode drives both battery status lines high.
// [R4] I/O mode holds the speaker output high.
// [R5] I/O mode reports configuration status change on the status-change line.
// [R6] ATA mode uses pass-diagnostic and drive-active/slave-present lines.
// [R7] both card-detect outputs sit at ground in every mode.
// [R8] card enables are active low; they with A0 pick byte, word or odd.
// [R9] ATA: enable two selects control registers, enable one the rest.
// [R10] ATA: cable select grounded means master, open means slave.
// [R11] memory mode ignores cable select and I/O read.
// [R12] I/O mode drives input acknowledge low during a selected I/O read.
// [R13] host leaves input acknowledge open in memory and ATA modes.
// [R14] I/O read strobes task-file reads, ignored until mode set up.
// [R15] I/O write strobes task-file writes, ignored until mode set up.
// [R16] memory mode: register select high is task file, low attribute.
// [R17] host grounds the ATA select pin to enter ATA mode.
// [R18] both enables word; enable one byte by A0; enable two odd high.
module fchp_pins
    import fchp_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   srst_i,
    // host pins, all asynchronous to clk_i
    input  wire logic [FCHP_ADDR_W-1:0] addr_i,
    input  wire logic                   ce1_n_i,
    input  wire logic                   ce2_n_i,
    input  wire logic                   reg_n_i,
    input  wire logic                   iord_n_i,
    input  wire logic                   iowr_n_i,
    input  wire logic                   atasel_n_i,
    input  wire logic                   csel_n_i,
    // configuration from the card's own logic
    input  wire logic                   io_cfg_i,
    input  wire logic                   setup_done_i,
    input  wire logic                   stat_chg_i,
    input  wire logic                   diag_pass_i,
    input  wire logic                   drive_active_i,
    // pin side
    output logic                        cd1_n_o,
    output logic                        cd2_n_o,
    output logic                        inpack_n_o,
    output logic                        inpack_oe_o,
    output logic                        bvd1_o,
    output logic                        bvd1_oe_o,
    output logic                        bvd2_o,
    output logic                        bvd2_oe_o,
    // card side
    output fchp_mode_e                  mode_o,
    output logic                        master_o,
    output fchp_xfer_e                  xfer_o,
    output fchp_tgt_e                   tgt_o,
    output logic [FCHP_ADDR_W-1:0]      dec_addr_o,
    output logic                        rd_stb_o,
    output logic                        wr_stb_o
);

    localparam int NPIN = FCHP_ADDR_W + 7;

    logic [NPIN-1:0]        pin_s;
    logic [FCHP_ADDR_W-1:0] a_s;
    logic                   ce1_s;
    logic                   ce2_s;
    logic                   reg_s;
    logic                   iord_s;
    logic                   iowr_s;
    logic                   atasel_s;
    logic                   csel_s;
    logic                   iord_d1_q;
    logic                   iowr_d1_q;
    fchp_mode_e             mode_q;
    logic                   master_q;
    fchp_xfer_e             xfer_q;
    fchp_tgt_e              tgt_q;
    logic [FCHP_ADDR_W-1:0] dec_addr_q;
    logic                   rd_stb_q;
    logic                   wr_stb_q;
    logic                   inpack_q;
    logic                   stschg_q;
    logic                   bvd1_q;
    logic                   bvd2_q;
    logic                   io_ok;

    // lane decode, used for every mode
    function automatic fchp_xfer_e lane_dec(input logic ce1_n, input logic ce2_n,
                                            input logic a0);
        if (!ce1_n && !ce2_n) begin
            return FCHP_XFER_WORD; // [R18]
        end else if (!ce1_n) begin
            return a0 ? FCHP_XFER_ODD_LO : FCHP_XFER_EVEN; // [R8] [R18]
        end else if (!ce2_n) begin
            return FCHP_XFER_ODD_HI; // [R18]
        end
        return FCHP_XFER_NONE;
    endfunction

    // all host pins pass the three-stage filter
    fchp_sync #(.W(NPIN)) u_sync (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .async_i   ({addr_i, ce1_n_i, ce2_n_i, reg_n_i, iord_n_i, iowr_n_i,
                     atasel_n_i, csel_n_i}),
        .rst_val_i ({NPIN{1'b1}}),
        .sync_o    (pin_s)
    );

    assign a_s      = pin_s[NPIN-1:7];
    assign ce1_s    = pin_s[6];
    assign ce2_s    = pin_s[5];
    assign reg_s    = pin_s[4];
    assign iord_s   = pin_s[3];
    assign iowr_s   = pin_s[2];
    assign atasel_s = pin_s[1];
    assign csel_s   = pin_s[0];

    // strobes only count once the mode is set up
    assign io_ok = setup_done_i && (mode_q != FCHP_MODE_MEM); // [R14] [R15]

    // mode follows the ATA select pin and the card's configuration
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_q <= fchp_mode_e'(FCHP_RST_MODE);
        end else if (!atasel_s) begin
            mode_q <= FCHP_MODE_ATA; // [R17]
        end else begin
            mode_q <= io_cfg_i ? FCHP_MODE_IO : FCHP_MODE_MEM;
        end
    end

    // master/slave only sampled in ATA mode; memory mode keeps old value
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            master_q <= FCHP_RST_MASTER;
        end else if (mode_q == FCHP_MODE_ATA) begin
            master_q <= !csel_s; // [R10] [R11]
        end
    end

    // address and target decode
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            xfer_q     <= FCHP_XFER_NONE;
            tgt_q      <= FCHP_TGT_NONE;
            dec_addr_q <= '0;
        end else begin
            xfer_q <= lane_dec(ce1_s, ce2_s, a_s[0]); // [R8]
            if (mode_q == FCHP_MODE_ATA) begin
                dec_addr_q <= {{(FCHP_ADDR_W-FCHP_ATA_ADDR_W){1'b0}},
                               a_s[FCHP_ATA_ADDR_W-1:0]}; // [R2]
                if (!ce2_s) begin
                    tgt_q <= FCHP_TGT_ATA_CTL; // [R9]
                end else if (!ce1_s) begin
                    tgt_q <= FCHP_TGT_ATA_CMD; // [R9]
                end else begin
                    tgt_q <= FCHP_TGT_NONE;
                end
            end else begin
                dec_addr_q <= a_s; // [R1]
                if (ce1_s && ce2_s) begin
                    tgt_q <= FCHP_TGT_NONE;
                end else if (mode_q == FCHP_MODE_IO) begin
                    tgt_q <= reg_s ? FCHP_TGT_NONE : FCHP_TGT_IO;
                end else begin
                    tgt_q <= reg_s ? FCHP_TGT_TASK : FCHP_TGT_ATTR; // [R16]
                end
            end
        end
    end

    // one-cycle strobes on the falling edge of the filtered pins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            iord_d1_q <= 1'b1;
            iowr_d1_q <= 1'b1;
            rd_stb_q  <= 1'b0;
            wr_stb_q  <= 1'b0;
        end else begin
            iord_d1_q <= iord_s;
            iowr_d1_q <= iowr_s;
            rd_stb_q  <= io_ok && iord_d1_q && !iord_s && !(ce1_s && ce2_s); // [R14] [R11]
            wr_stb_q  <= io_ok && iowr_d1_q && !iowr_s && !(ce1_s && ce2_s); // [R15]
        end
    end

    // input acknowledge follows a selected I/O read
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            inpack_q <= 1'b0;
        end else begin
            inpack_q <= (mode_q == FCHP_MODE_IO) && setup_done_i
                        && !(ce1_s && ce2_s) && !reg_s && !iord_s; // [R12]
        end
    end

    // shared status pins: levels per mode
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bvd1_q   <= 1'b1;
            bvd2_q   <= 1'b1;
            stschg_q <= 1'b0;
        end else begin
            stschg_q <= stat_chg_i;
            unique case (mode_q)
                FCHP_MODE_MEM: begin
                    bvd1_q <= 1'b1; // [R3]
                    bvd2_q <= 1'b1; // [R3]
                end
                FCHP_MODE_IO: begin
                    bvd1_q <= !stat_chg_i; // [R5]
                    bvd2_q <= 1'b1;        // [R4]
                end
                FCHP_MODE_ATA: begin
                    bvd1_q <= !diag_pass_i;    // [R6]
                    bvd2_q <= !drive_active_i; // [R6]
                end
                default: begin
                    bvd1_q <= 1'b1;
                    bvd2_q <= 1'b1;
                end
            endcase
        end
    end

    // card detect strapped low regardless of mode
    assign cd1_n_o = 1'b0; // [R7]
    assign cd2_n_o = 1'b0; // [R7]

    // acknowledge only driven in I/O mode; the host leaves it open otherwise
    assign inpack_n_o  = !inpack_q;                  // [R12]
    assign inpack_oe_o = (mode_q == FCHP_MODE_IO);   // [R13]
    assign bvd1_o      = bvd1_q;
    assign bvd1_oe_o   = 1'b1;
    assign bvd2_o      = bvd2_q;
    assign bvd2_oe_o   = 1'b1;
    assign mode_o      = mode_q;
    assign master_o    = master_q;
    assign xfer_o      = xfer_q;
    assign tgt_o       = tgt_q;
    assign dec_addr_o  = dec_addr_q;
    assign rd_stb_o    = rd_stb_q;
    assign wr_stb_o    = wr_stb_q;

    a_mem_bvd_high: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(mode_q) == FCHP_MODE_MEM && mode_q == FCHP_MODE_MEM |-> bvd1_o && bvd2_o)
        else $error("battery status not high in memory mode"); // [R3]
    a_io_spkr_high: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(mode_q) == FCHP_MODE_IO && mode_q == FCHP_MODE_IO |-> bvd2_o)
        else $error("speaker line not high in io mode"); // [R4]
    a_io_stschg: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_IO |=> (mode_q != FCHP_MODE_IO) || (bvd1_o == !stschg_q))
        else $error("status change not reported"); // [R5]
    a_ata_diag: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_ATA && diag_pass_i |=> mode_q != FCHP_MODE_ATA || !bvd1_o)
        else $error("diagnostic line not asserted"); // [R6]
    a_card_detect: assert property (@(posedge clk_i) !cd1_n_o && !cd2_n_o)
        else $error("card detect not grounded"); // [R7]
    a_word_lane: assert property (@(posedge clk_i) disable iff (srst_i)
        !ce1_s && !ce2_s |=> xfer_o == FCHP_XFER_WORD)
        else $error("word access not decoded"); // [R18]
    a_ata_ctl_sel: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_ATA && !ce2_s |=> tgt_o == FCHP_TGT_ATA_CTL)
        else $error("control register not selected"); // [R9]
    a_ata_addr_cut: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_ATA |=> dec_addr_o[FCHP_ADDR_W-1:FCHP_ATA_ADDR_W] == '0)
        else $error("high address lines decoded in ata mode"); // [R2]
    a_ata_master: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_ATA |=> master_o == !$past(csel_s))
        else $error("master/slave wrong"); // [R10]
    a_mem_no_strobe: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_MEM || !setup_done_i |=> !rd_stb_o && !wr_stb_o)
        else $error("strobe before setup or in memory mode"); // [R11] [R14] [R15]
    a_mem_reg_sel: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_MEM && !ce1_s && !reg_s |=> tgt_o == FCHP_TGT_ATTR)
        else $error("attribute space not selected"); // [R16]
    a_inpack_ack: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_IO && setup_done_i && !ce1_s && !reg_s && !iord_s
        |=> !inpack_n_o)
        else $error("input acknowledge missing"); // [R12]
    a_full_addr: assert property (@(posedge clk_i) disable iff (srst_i)
        mode_q != FCHP_MODE_ATA |=> dec_addr_o == $past(a_s))
        else $error("address not passed whole"); // [R1]

    c_io_read: cover property (@(posedge clk_i) disable iff (srst_i) rd_stb_o && !inpack_n_o);
    c_ata_write: cover property (@(posedge clk_i) disable iff (srst_i)
        wr_stb_o && mode_q == FCHP_MODE_ATA);
    c_odd_hi: cover property (@(posedge clk_i) disable iff (srst_i) xfer_o == FCHP_XFER_ODD_HI);
    c_slave: cover property (@(posedge clk_i) disable iff (srst_i)
        mode_q == FCHP_MODE_ATA && !master_o);

endmodule // fchp_pins
`default_nettype wire

// >>> sim/fchp_host.sv
`timescale 1ns/10ps
`default_nettype none
// host slot adapter model: drives card pins a little after each rising edge
module fchp_host
    import fchp_pkg::*;
(
    input  wire logic                   clk_i,
    output logic [FCHP_ADDR_W-1:0]      addr_o,
    output logic                        ce1_n_o,
    output logic                        ce2_n_o,
    output logic                        reg_n_o,
    output logic                        iord_n_o,
    output logic                        iowr_n_o,
    output logic                        atasel_n_o,
    output logic                        csel_n_o
);
    // strobe low and high time, kept above the two-cycle filter minimum
    localparam int HOLD = 6;

    // idle control pins high, address lines low; acknowledge is not wired to this adapter
    initial begin
        addr_o     = '0;
        ce1_n_o    = 1'b1;
        ce2_n_o    = 1'b1;
        reg_n_o    = 1'b1;
        iord_n_o   = 1'b1;
        iowr_n_o   = 1'b1;
        atasel_n_o = 1'b1;
        csel_n_o   = 1'b1;
    end

    // ground the select pin for ATA, leave it high otherwise
    task automatic go_mode(input logic ata);
        @(posedge clk_i);
        #1;
        atasel_n_o = !ata;
    endtask

    // present one access; ATA keeps upper address lines grounded
    task automatic put(input logic [FCHP_ADDR_W-1:0] a, input logic c1, c2, r, cs, ata);
        @(posedge clk_i);
        #1;
        addr_o   = ata ? (a & 11'h007) : a;
        ce1_n_o  = c1;
        ce2_n_o  = c2;
        reg_n_o  = ata ? 1'b1 : r;
        csel_n_o = cs;
    endtask

    // one read or write strobe, spacing held on both sides
    task automatic pulse(input logic rd, input logic wr);
        @(posedge clk_i);
        #1;
        iord_n_o = !rd;
        iowr_n_o = !wr;
        repeat (HOLD) @(posedge clk_i);
        #1;
        iord_n_o = 1'b1;
        iowr_n_o = 1'b1;
        repeat (HOLD) @(posedge clk_i);
    endtask
endmodule // fchp_host
`default_nettype wire

// >>> sim/test_flash_card_host_pin_interface.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_flash_card_host_pin_interface
    import fchp_pkg::*;
();
    logic                   clk_i, srst_i;
    logic [FCHP_ADDR_W-1:0] addr, dec_addr;
    logic                   ce1_n, ce2_n, reg_n, iord_n, iowr_n, atasel_n, csel_n;
    logic                   io_cfg, setup_done, stat_chg, diag_pass, drive_active;
    logic                   cd1_n, cd2_n, inpack_n, inpack_oe, bvd1, bvd1_oe, bvd2, bvd2_oe;
    logic                   master, rd_stb, wr_stb;
    fchp_mode_e             mode;
    fchp_xfer_e             xfer, ex;
    fchp_tgt_e              tgt, et;
    int                     errors, n_tests, cyc, rd_cnt, wr_cnt, r0, w0;
    int                     m, a, c, r, cs, exp_master, rd, wr;

    fchp_host hst (.clk_i(clk_i), .addr_o(addr), .ce1_n_o(ce1_n), .ce2_n_o(ce2_n),
        .reg_n_o(reg_n), .iord_n_o(iord_n), .iowr_n_o(iowr_n), .atasel_n_o(atasel_n),
        .csel_n_o(csel_n));

    fchp_pins DUT (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr), .ce1_n_i(ce1_n),
        .ce2_n_i(ce2_n), .reg_n_i(reg_n), .iord_n_i(iord_n), .iowr_n_i(iowr_n),
        .atasel_n_i(atasel_n), .csel_n_i(csel_n), .io_cfg_i(io_cfg),
        .setup_done_i(setup_done), .stat_chg_i(stat_chg), .diag_pass_i(diag_pass),
        .drive_active_i(drive_active), .cd1_n_o(cd1_n), .cd2_n_o(cd2_n),
        .inpack_n_o(inpack_n), .inpack_oe_o(inpack_oe), .bvd1_o(bvd1), .bvd1_oe_o(bvd1_oe),
        .bvd2_o(bvd2), .bvd2_oe_o(bvd2_oe), .mode_o(mode), .master_o(master),
        .xfer_o(xfer), .tgt_o(tgt), .dec_addr_o(dec_addr), .rd_stb_o(rd_stb),
        .wr_stb_o(wr_stb));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // strobe pulse tally and hang guard, ceiling well above the ~2700 cycles used
    always @(posedge clk_i) begin
        cyc++;
        rd_cnt += int'(rd_stb === 1'b1);
        wr_cnt += int'(wr_stb === 1'b1);
        if (cyc == 12000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // settled pin and decode outputs against the reference model
    task automatic check_all();
        ex = (c == 0) ? FCHP_XFER_WORD : (c == 2) ? FCHP_XFER_ODD_HI : (c == 3) ?
            FCHP_XFER_NONE : (a % 2) ? FCHP_XFER_ODD_LO : FCHP_XFER_EVEN;
        if (c == 3) et = FCHP_TGT_NONE;
        else if (m == 0) et = r ? FCHP_TGT_TASK : FCHP_TGT_ATTR;
        else if (m == 1) et = r ? FCHP_TGT_NONE : FCHP_TGT_IO;
        else et = (c % 2 == 0) ? FCHP_TGT_ATA_CTL : FCHP_TGT_ATA_CMD;
        `CHK(mode, fchp_mode_e'(m))
        `CHK(master, 1'(exp_master))
        `CHK(xfer, ex)
        `CHK(tgt, et)
        `CHK(dec_addr, 11'((m == 2) ? (a & 7) : a))
        `CHK({cd1_n, cd2_n}, 2'h0)
        `CHK({bvd1_oe, bvd2_oe}, 2'h3)
        `CHK(bvd1, 1'((m == 0) ? 1 : (m == 1) ? !stat_chg : !diag_pass))
        `CHK(bvd2, 1'((m == 2) ? !drive_active : 1))
        `CHK(inpack_oe, 1'(m == 1))
        `CHK(inpack_n, 1'h1)
    endtask

    // reset, then random accesses across all three modes
    initial begin
        srst_i = 1'b1;
        {io_cfg, setup_done, stat_chg, diag_pass, drive_active} = '0;
        {errors, n_tests, cyc, rd_cnt, wr_cnt} = '0;
        {m, a, c, r} = '0;
        c = 3;
        exp_master = 1;
        void'($urandom(32'h77a5));
        repeat (5) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        check_all();
        for (int i = 0; i < 100; i++) begin
            m = $urandom_range(2, 0);
            a = $urandom_range(2047, 0);
            c = $urandom_range(3, 0);
            r = (m == 2) ? 1 : $urandom_range(1, 0);
            cs = $urandom_range(1, 0);
            // mode pins settle first so cable select is never sampled mid-switch
            hst.go_mode(m == 2);
            io_cfg = (m == 1);
            repeat (6) @(posedge clk_i);
            hst.put(11'(a), c[1], c[0], r[0], cs[0], m == 2);
            setup_done = ($urandom_range(3, 0) != 0);
            {stat_chg, diag_pass, drive_active} = 3'($urandom_range(7, 0));
            if (m == 2) exp_master = !cs;
            repeat (6) @(posedge clk_i);
            #1;
            check_all();
            rd = $urandom_range(1, 0);
            wr = !rd;
            r0 = rd_cnt;
            w0 = wr_cnt;
            fork
                hst.pulse(rd[0], wr[0]);
                begin
                    repeat (6) @(posedge clk_i);
                    #2;
                    `CHK(inpack_n, 1'(!(m == 1 && setup_done && c != 3 && !r && rd)))
                end
            join
            `CHK(rd_cnt - r0, int'(rd && m != 0 && setup_done && c != 3))
            `CHK(wr_cnt - w0, int'(wr && m != 0 && setup_done && c != 3))
        end
        complete_run();
    end
endmodule // test_flash_card_host_pin_interface
`default_nettype wire
